// [src/rfgf_pkg.sv]
// package: constants, register map and carrier structs of the rail fault glitch filter
// Notes on behaviour
// - comparator result updates every 1.333 us
// - fault needs four consecutive faulting updates
// - each filter clock shifts one sample in
// - match high when shift register equals seed
// - all-ones seed: fault only on eight ones
// - zero polynomial: plain shift, no scrambling
// - filter samples at 1.5 MHz, twice update rate
// - pulses shorter than 5.33 us are rejected
// - undervoltage select: bus 0, input inverted
// - one independent 8-bit filter per comparator
// - four rails, 10 us slots, 40 us cycle
// - slot fault caught only if early enough
// - latency between 5.33 us and 40.66 us
// - any fault raises the power-good interrupt
// - overvoltage indicator pin, no interrupt of own
// - handler reads indicator to classify fault
// - overvoltage comparator is low on fault
package rfgf_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int CMP_CLK_HZ = 3000000;
    localparam int CMP_DIV = 4;
    localparam int SAMPLE_HZ = 1500000;
    localparam int SLOT_NS = 10000;
    localparam int RAIL_COUNT = 4;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int SLOT_CYC = (SLOT_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int FW = 8;
    localparam int NFILT = 2;
    localparam int UV_CH = 0;
    localparam int OV_CH = 1;
    localparam int AW = 4;
    localparam logic [AW-1:0] A_SEL_UV = 4'h0;
    localparam logic [AW-1:0] A_SEL_OV = 4'h1;
    localparam logic [AW-1:0] A_SEED_UV = 4'h2;
    localparam logic [AW-1:0] A_SEED_OV = 4'h3;
    localparam logic [AW-1:0] A_POLY_UV = 4'h4;
    localparam logic [AW-1:0] A_POLY_OV = 4'h5;
    localparam logic [AW-1:0] A_CTRL = 4'h6;
    localparam logic [AW-1:0] A_STATUS = 4'h7;
    localparam logic [AW-1:0] A_MASK = 4'h8;
    localparam logic [AW-1:0] A_LIVE = 4'h9;
    localparam logic [AW-1:0] A_SHIFT_UV = 4'ha;
    localparam logic [AW-1:0] A_SHIFT_OV = 4'hb;
    localparam int SEL_INV_BIT = 7;
    localparam int SEL_BUS_LSB = 4;
    localparam logic [FW-1:0] SEL_UV_RST = 8'hc0;
    localparam logic [FW-1:0] SEL_OV_RST = 8'hd0;
    localparam logic [FW-1:0] SEED_RST = 8'hff;
    localparam logic [FW-1:0] POLY_RST = 8'h00;
    localparam logic [FW-1:0] ZERO8 = 8'h00;
    // line 0 only is inverted here; the undervoltage select inversion cancels it, line 1 passes straight
    localparam logic [NFILT-1:0] CMP_LINE_POL = 2'h1;
    // idle pin levels: no undervoltage (low), no overvoltage (high)
    localparam logic [NFILT-1:0] CMP_IDLE = 2'h2;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_UV_BIT = 0;
    localparam int ST_OV_BIT = 1;

    typedef struct packed {
        logic [FW-1:0] sel;
        logic [FW-1:0] seed;
        logic [FW-1:0] poly;
        logic [FW-1:0] shreg;
        logic match;
    } rfgf_filt_s;

    typedef struct packed {
        rfgf_filt_s [NFILT-1:0] f;
        logic [4:0] div;
        logic [3:0] slot_cnt;
        logic [1:0] rail;
        logic enable;
        logic [NFILT-1:0] status;
        logic [NFILT-1:0] mask;
        logic [FW-1:0] rdata;
        logic irq;
        logic ov_pin;
        logic [NFILT-1:0] sync1;
        logic [NFILT-1:0] sync2;
        logic [NFILT-1:0] sync3;
        logic [NFILT-1:0] bus;
    } rfgf_state_s;
endpackage

// [src/rfgf_top.sv]
// rail fault glitch filter: sampling, shift/compare filters, rail mux, interrupt, registers
`timescale 1ns/1ps
module rfgf_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // comparator bus pins: bus 0 undervoltage, bus 1 overvoltage
    input wire logic [rfgf_pkg::NFILT-1:0] cmp_bus_i,
    // register port
    input wire logic [rfgf_pkg::AW-1:0] addr_i,
    input wire logic [rfgf_pkg::FW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [rfgf_pkg::FW-1:0] rdata_o,
    // fault outputs
    output logic power_good_interrupt_o,
    output logic overvoltage_fault_o,
    output logic [1:0] rail_sel_o
);
    rfgf_pkg::rfgf_state_s r, next_r;
    logic sample_tick;
    logic [rfgf_pkg::NFILT-1:0] fin;
    logic [rfgf_pkg::NFILT-1:0] fault_evt;

    // filter input: selected bus, optional inversion
    genvar g;
    generate
        for (g = 0; g < rfgf_pkg::NFILT; g++) begin : g_in
            logic busbit;
            logic [rfgf_pkg::NFILT-1:0] line;
            // select-bit inversion then turns both lines into active-high faults
            assign line = r.bus ^ rfgf_pkg::CMP_LINE_POL;
            assign busbit = r.f[g].sel[rfgf_pkg::SEL_BUS_LSB] ? line[1] : line[0];
            // overvoltage bus is low on fault, inversion makes both active high
            assign fin[g] = busbit ^ r.f[g].sel[rfgf_pkg::SEL_INV_BIT];
            assign fault_evt[g] = r.f[g].match;
        end
    endgenerate

    assign sample_tick = (r.div == 5'(rfgf_pkg::SAMPLE_DIV - 1));

    always_comb begin
        next_r = r;
        next_r.rdata = rfgf_pkg::ZERO8;
        // three-stage pin synchroniser; only stage 2/3 agreement is used
        next_r.sync1 = cmp_bus_i;
        next_r.sync2 = r.sync1;
        next_r.sync3 = r.sync2;
        for (int i = 0; i < rfgf_pkg::NFILT; i++) begin
            if (r.sync2[i] == r.sync3[i]) begin
                next_r.bus[i] = r.sync3[i];
            end
        end
        next_r.div = sample_tick ? 5'h00 : 5'(r.div + 5'h01);
        // rail slot sequencing, 40 us round of four 10 us slots
        if (r.slot_cnt == 4'(rfgf_pkg::SLOT_CYC / rfgf_pkg::SAMPLE_DIV - 1)) begin
            if (sample_tick) begin
                next_r.slot_cnt = 4'h0;
                next_r.rail = 2'(r.rail + 2'h1);
            end
        end else if (sample_tick) begin
            next_r.slot_cnt = 4'(r.slot_cnt + 4'h1);
        end
        if (sample_tick && r.enable) begin
            for (int i = 0; i < rfgf_pkg::NFILT; i++) begin
                // zero polynomial leaves a plain shift
                next_r.f[i].shreg = {r.f[i].shreg[rfgf_pkg::FW-2:0], fin[i]}
                    ^ (r.f[i].shreg[rfgf_pkg::FW-1] ? r.f[i].poly : rfgf_pkg::ZERO8);
                // eight samples at twice update rate = four updates, 5.33 us
                next_r.f[i].match = (next_r.f[i].shreg == r.f[i].seed);
            end
        end
        // fresh rail starts clean so a fault is judged within its slot
        if (sample_tick && r.slot_cnt == 4'h0 && r.enable) begin
            for (int i = 0; i < rfgf_pkg::NFILT; i++) begin
                next_r.f[i].shreg = {rfgf_pkg::ZERO8[rfgf_pkg::FW-1:1], fin[i]};
                next_r.f[i].match = 1'b0;
            end
        end
        // register writes; a set in the same cycle wins over the clear
        if (wr_i) begin
            case (addr_i)
                rfgf_pkg::A_SEL_UV: next_r.f[rfgf_pkg::UV_CH].sel = wdata_i;
                rfgf_pkg::A_SEL_OV: next_r.f[rfgf_pkg::OV_CH].sel = wdata_i;
                rfgf_pkg::A_SEED_UV: next_r.f[rfgf_pkg::UV_CH].seed = wdata_i;
                rfgf_pkg::A_SEED_OV: next_r.f[rfgf_pkg::OV_CH].seed = wdata_i;
                rfgf_pkg::A_POLY_UV: next_r.f[rfgf_pkg::UV_CH].poly = wdata_i;
                rfgf_pkg::A_POLY_OV: next_r.f[rfgf_pkg::OV_CH].poly = wdata_i;
                rfgf_pkg::A_CTRL: next_r.enable = wdata_i[rfgf_pkg::CTRL_EN_BIT];
                rfgf_pkg::A_STATUS: next_r.status = r.status & ~wdata_i[rfgf_pkg::NFILT-1:0];
                rfgf_pkg::A_MASK: next_r.mask = wdata_i[rfgf_pkg::NFILT-1:0];
                default: ;
            endcase
        end
        // both filter matches feed the shared interrupt; overvoltage has none of its own
        next_r.status = next_r.status | fault_evt;
        next_r.irq = |(next_r.status & next_r.mask);
        // indicator pin follows the filter, firmware reads it to classify
        next_r.ov_pin = r.f[rfgf_pkg::OV_CH].match;
        if (rd_i) begin
            case (addr_i)
                rfgf_pkg::A_SEL_UV: next_r.rdata = r.f[rfgf_pkg::UV_CH].sel;
                rfgf_pkg::A_SEL_OV: next_r.rdata = r.f[rfgf_pkg::OV_CH].sel;
                rfgf_pkg::A_SEED_UV: next_r.rdata = r.f[rfgf_pkg::UV_CH].seed;
                rfgf_pkg::A_SEED_OV: next_r.rdata = r.f[rfgf_pkg::OV_CH].seed;
                rfgf_pkg::A_POLY_UV: next_r.rdata = r.f[rfgf_pkg::UV_CH].poly;
                rfgf_pkg::A_POLY_OV: next_r.rdata = r.f[rfgf_pkg::OV_CH].poly;
                rfgf_pkg::A_CTRL: next_r.rdata = {7'h00, r.enable};
                rfgf_pkg::A_STATUS: next_r.rdata = {6'h00, r.status};
                rfgf_pkg::A_MASK: next_r.rdata = {6'h00, r.mask};
                rfgf_pkg::A_LIVE: next_r.rdata = {4'h0, r.rail, r.f[1].match, r.f[0].match};
                rfgf_pkg::A_SHIFT_UV: next_r.rdata = r.f[rfgf_pkg::UV_CH].shreg;
                rfgf_pkg::A_SHIFT_OV: next_r.rdata = r.f[rfgf_pkg::OV_CH].shreg;
                default: next_r.rdata = rfgf_pkg::ZERO8;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.f[rfgf_pkg::UV_CH].sel <= rfgf_pkg::SEL_UV_RST;
            r.f[rfgf_pkg::OV_CH].sel <= rfgf_pkg::SEL_OV_RST;
            r.f[rfgf_pkg::UV_CH].seed <= rfgf_pkg::SEED_RST;
            r.f[rfgf_pkg::OV_CH].seed <= rfgf_pkg::SEED_RST;
            r.f[rfgf_pkg::UV_CH].poly <= rfgf_pkg::POLY_RST;
            r.f[rfgf_pkg::OV_CH].poly <= rfgf_pkg::POLY_RST;
            r.enable <= 1'b1;
            // idle levels, so the released synchroniser shows no false fault
            r.sync1 <= rfgf_pkg::CMP_IDLE;
            r.sync2 <= rfgf_pkg::CMP_IDLE;
            r.sync3 <= rfgf_pkg::CMP_IDLE;
            r.bus <= rfgf_pkg::CMP_IDLE;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign rdata_o = r.rdata;
    assign power_good_interrupt_o = r.irq;
    assign overvoltage_fault_o = r.ov_pin;
    assign rail_sel_o = r.rail;
endmodule

// [dv/rfgf_props.sv]
// checker: port-level properties of the rail fault glitch filter
`timescale 1ns/1ps
module rfgf_props (
    // clock, reset and inputs
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [1:0] cmp_bus_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    // outputs
    input wire logic [7:0] rdata_o,
    input wire logic power_good_interrupt_o,
    input wire logic overvoltage_fault_o,
    input wire logic [1:0] rail_sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence ov_back_s;
        $rose(cmp_bus_i[1]) ##1 cmp_bus_i[1] [*8];
    endsequence
    sequence quiet_s;
        (!overvoltage_fault_o && !power_good_interrupt_o && rail_sel_o == 2'd0) [*8];
    endsequence
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its slot");
    unmapped_rd_a: assert property (rd_i && ce_i && addr_i > 4'hb |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    poly_zero_a: assert property (rd_i && ce_i && addr_i == 4'h4 |=> rdata_o == 8'h00)
        else $error("polynomial not zero");
    rail_step_a: assert property ($changed(rail_sel_o) |-> rail_sel_o == 2'($past(rail_sel_o) + 2'd1))
        else $error("rail skipped");
    rail_hold_a: assert property ($changed(rail_sel_o) |=> $stable(rail_sel_o) [*8])
        else $error("rail slot too short");
    // rise needs the bus faulting 30 and 110 cycles back, two points inside the eight-sample window
    ov_rise_a: assert property ($rose(overvoltage_fault_o) |->
        !$past(cmp_bus_i[1], 30) && !$past(cmp_bus_i[1], 110))
        else $error("overvoltage flagged without sustained fault");
    ov_release_a: assert property (ov_back_s |-> ##[0:48] !overvoltage_fault_o)
        else $error("overvoltage indicator stuck");
    irq_mask_a: assert property (wr_i && ce_i && addr_i == 4'h8 && wdata_i == 8'h00
        |-> ##2 !power_good_interrupt_o)
        else $error("masked interrupt still high");
    quiet_start_a: assert property ($rose(resetn_i) |-> quiet_s)
        else $error("fault right after reset");
endmodule

bind rfgf_top rfgf_props u_rfgf_props (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .cmp_bus_i(cmp_bus_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .power_good_interrupt_o(power_good_interrupt_o),
    .overvoltage_fault_o(overvoltage_fault_o), .rail_sel_o(rail_sel_o));

// [dv/rfgf_cmp_model.sv]
// comparator model: window comparator outputs on the two comparator bus pins
`timescale 1ns/1ps
module rfgf_cmp_model (
    input wire logic clk_i,
    input wire logic [1:0] rail_sel_i,
    input wire logic [1:0] fault_rail_i,
    input wire logic uv_on_i,
    input wire logic ov_on_i,
    output logic [1:0] cmp_bus_o
);
    logic [5:0] cnt = 6'h00;
    logic hit;
    initial cmp_bus_o = 2'b10;
    assign hit = rail_sel_i == fault_rail_i;
    // outputs move only once per comparator update, 33 clocks
    always @(posedge clk_i) begin
        cnt <= (cnt == 6'h20) ? 6'h00 : cnt + 6'h01;
        // faulty rail seen only on its mux slot; overvoltage is low on fault
        if (cnt == 6'h20) cmp_bus_o <= {!(ov_on_i && hit), uv_on_i && hit};
    end
endmodule

// [dv/rfgf_top_test.sv]
// testbench: registers, glitch rejection and fault reporting of the glitch filter
`timescale 1ns/1ps
module rfgf_top_test;
    logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    logic uv_on = 1'b0, ov_on = 1'b0, irq, ovp;
    logic [1:0] fault_rail = 2'h0, rail, cmp_bus;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, rv;
    logic [7:0] exp_q[$];
    int err_count = 0, comparisons = 0, n;
    rfgf_top u_rfgf_top (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cmp_bus_i(cmp_bus),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .power_good_interrupt_o(irq), .overvoltage_fault_o(ovp), .rail_sel_o(rail));
    rfgf_cmp_model u_rfgf_cmp_model (.clk_i(clk_i), .rail_sel_i(rail), .fault_rail_i(fault_rail),
        .uv_on_i(uv_on), .ov_on_i(ov_on), .cmp_bus_o(cmp_bus));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one strobe cycle; a read notes its expected data for the monitor
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d) begin
            rv = exp_q.pop_front();
            chk(rdata_o, rv);
        end
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(80712));
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        bus(0, 4'h0, 8'hc0);
        bus(0, 4'h1, 8'hd0);
        bus(0, 4'h2, 8'hff);
        bus(0, 4'h4, 8'h00);
        bus(0, 4'ha, 8'h00);
        bus(0, 4'hc, 8'h00);
        // a zero seed would match the idle all-zero shift register
        n = $urandom | 1;
        bus(1, 4'h3, n[7:0]);
        bus(0, 4'h3, n[7:0]);
        bus(1, 4'h3, 8'hff);
        $display("registers done");
        // a 90-clock pulse spans at most seven samples
        bus(1, 4'h8, 8'h03);
        fault_rail <= rail;
        ov_on <= 1'b1;
        repeat (90) @(posedge clk_i);
        ov_on <= 1'b0;
        repeat (60) @(posedge clk_i);
        bus(0, 4'h7, 8'h00);
        $display("glitch done");
        fault_rail <= n[9:8];
        uv_on <= 1'b1;
        for (n = 0; n < 1100 && irq !== 1'b1; n++) @(negedge clk_i);
        chk({7'h0, n > 130 && n < 1100}, 8'h01);
        chk({7'h0, ovp}, 8'h00);
        uv_on <= 1'b0;
        repeat (100) @(posedge clk_i);
        bus(0, 4'h7, 8'h01);
        bus(1, 4'h7, 8'h01);
        bus(0, 4'h7, 8'h00);
        $display("undervoltage done");
        ov_on <= 1'b1;
        for (n = 0; n < 1100 && ovp !== 1'b1; n++) @(negedge clk_i);
        chk({7'h0, n < 1100}, 8'h01);
        repeat (3) @(negedge clk_i);
        chk({7'h0, irq}, 8'h01);
        bus(0, 4'h7, 8'h02);
        ov_on <= 1'b0;
        bus(1, 4'h8, 8'h00);
        @(negedge clk_i);
        chk({7'h0, irq}, 8'h00);
        repeat (300) @(posedge clk_i);
        $display("overvoltage done");
        give_verdict();
    end
endmodule
